// >>> verilog/dcr_front.sv
// dcr_front: host register port and command dispatch of the drawing engine.
// assumes host strobes and engine handshake are synchronous to sys_clk.
// Function
// RULE_01: copies take top row from vertical field
// RULE_02: software loads axial step as 2*min
// RULE_03: copies take left column from horizontal field
// RULE_04: software loads diagonal step 2*(min-max)
// RULE_05: software loads error, minus one if rightward
// RULE_06: major count is pixels minus one
// RULE_07: queue occupancy as split thermometer code
// RULE_08: status bit 9 shows engine busy
// RULE_09: status bit 10 shows all slots empty
// RULE_10: software sets command bit 0
// RULE_11: bit 1 selects across-the-plane transfers
// RULE_12: bit 2 suppresses final line pixel
// RULE_13: bit 3 coding, bit 4 draw or move
// RULE_14: bits 7-5 encode drawing direction
// RULE_15: bit 8 routes data through host port
// RULE_16: bits 10-9 select host write width
// RULE_17: width code 11 only across-plane
// RULE_18: bit 12 sets host byte order
// RULE_19: bits 15-13 select the operation
// RULE_20: axial lines step by constants, radial by count
// RULE_21: pattern copy tiles 8x8 aligned source
// RULE_22: stroke word holds two ordered vectors
// RULE_23: shared address: reads status, writes command
`timescale 1ns/1ns
module dcr_front #(
  parameter int DEPTH = dcr_pkg::QUEUE_DEPTH
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // host register port
  input wire logic [15:0] host_addr,
  input wire logic host_wr,
  input wire logic host_rd,
  input wire logic [15:0] host_wdata,
  output logic [15:0] host_rdata,
  output logic host_rvalid,
  // engine datapath handshake
  output logic draw_req,
  output dcr_pkg::dcr_draw_t draw_order,
  input wire logic draw_ack,
  input wire logic draw_done
);
  import dcr_pkg::*;

  localparam int CW = $clog2(DEPTH+1);
  localparam int EW = $bits(dcr_entry_t);

  initial begin
    if (DEPTH < 2 || DEPTH > QUEUE_DEPTH) $error("dcr_front: depth must be 2..13");
  end

  typedef enum logic [1:0] {ST_IDLE, ST_ISSUE, ST_RUN} dcr_state_t;

  dcr_state_t state_ff;
  dcr_state_t nxt_state;
  logic [15:0] host_y_ff, host_x_ff, host_err_ff, host_major_ff;
  logic [15:0] work_y_ff, work_x_ff, work_err_ff, work_major_ff;
  logic [15:0] cmd_ff;
  logic [7:0] second_vec_ff;
  logic second_pending_ff;
  logic draw_req_ff;
  dcr_draw_t draw_ff;
  dcr_draw_t nxt_draw;
  logic [15:0] rdata_ff;
  logic rvalid_ff;
  logic busy_ff;
  logic push;
  logic pop;
  dcr_entry_t push_entry;
  dcr_entry_t head;
  logic [EW-1:0] head_bits;
  logic [CW-1:0] q_count;
  logic q_empty;
  logic q_full;
  logic addr_hit;
  dcr_target_t addr_tgt;
  logic [15:0] status_word;
  logic [15:0] nxt_rdata;
  logic [7:0] first_vec;
  logic [7:0] other_vec;

  ////////////////////////////////////////////////////////////////////////
  // address decode of host writes
  always_comb begin
    addr_hit = 1'b1;
    addr_tgt = TGT_DEST_Y;
    unique case (host_addr)
      ADDR_DEST_Y: addr_tgt = TGT_DEST_Y;
      ADDR_DEST_X: addr_tgt = TGT_DEST_X;
      ADDR_ERR: addr_tgt = TGT_ERR;
      ADDR_MAJOR: addr_tgt = TGT_MAJOR;
      ADDR_CMD: addr_tgt = TGT_CMD; // see RULE_23
      ADDR_STROKE: addr_tgt = TGT_STROKE;
      default: addr_hit = 1'b0;
    endcase
  end

  // every register write that finds a free slot travels through the queue in order
  assign push = host_wr && addr_hit;
  assign push_entry = '{target: addr_tgt, data: host_wdata};

  dcr_queue #(
    .WIDTH(EW),
    .DEPTH(DEPTH)
  ) u_queue (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .push(push),
    .push_data(push_entry),
    .pop(pop),
    .pop_data(head_bits),
    .count(q_count),
    .empty(q_empty),
    .full(q_full)
  );

  assign head = dcr_entry_t'(head_bits);
  assign pop = (state_ff == ST_IDLE) && !q_empty;

  ////////////////////////////////////////////////////////////////////////
  // host-visible copies of the parameter registers for readback
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      host_y_ff <= PARAM_RESET;
      host_x_ff <= PARAM_RESET;
      host_err_ff <= PARAM_RESET;
      host_major_ff <= PARAM_RESET;
    end else if (push && !q_full) begin
      unique case (addr_tgt)
        TGT_DEST_Y: host_y_ff <= host_wdata;
        TGT_DEST_X: host_x_ff <= host_wdata;
        TGT_ERR: host_err_ff <= host_wdata;
        TGT_MAJOR: host_major_ff <= host_wdata;
        TGT_CMD, TGT_STROKE: ;
      endcase
    end
  end

  // status word: thermometer of used slots, busy and all-empty
  always_comb begin
    logic [CW-1:0] free_slots;
    free_slots = CW'(DEPTH) - q_count;
    status_word = '0;
    for (int k = 1; k <= QUEUE_DEPTH; k++) begin
      if (k <= 8) begin
        status_word[8-k] = (free_slots < CW'(k)); // see RULE_07
      end else begin
        status_word[24-k] = (free_slots < CW'(k)); // see RULE_07
      end
    end
    status_word[STAT_BUSY_BIT] = busy_ff; // see RULE_08
    status_word[STAT_EMPTY_BIT] = q_empty; // see RULE_09
  end

  // read mux; reserved bits of parameters read as zero
  always_comb begin
    nxt_rdata = '0;
    unique case (host_addr)
      ADDR_DEST_Y: nxt_rdata = {2'h0, host_y_ff[STEP_W-1:0]};
      ADDR_DEST_X: nxt_rdata = {2'h0, host_x_ff[STEP_W-1:0]};
      ADDR_ERR: nxt_rdata = {2'h0, host_err_ff[STEP_W-1:0]};
      ADDR_MAJOR: nxt_rdata = {4'h0, host_major_ff[COORD_W-1:0]};
      ADDR_CMD: nxt_rdata = status_word; // see RULE_23
      default: nxt_rdata = '0;
    endcase
  end

  // read data registered, answered one cycle after the strobe
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_ff <= '0;
      rvalid_ff <= 1'b0;
    end else begin
      rvalid_ff <= host_rd;
      if (host_rd) begin
        rdata_ff <= nxt_rdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // engine-side working parameters, updated as entries leave the queue
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      work_y_ff <= PARAM_RESET;
      work_x_ff <= PARAM_RESET;
      work_err_ff <= PARAM_RESET;
      work_major_ff <= PARAM_RESET;
      cmd_ff <= CMD_RESET;
    end else if (pop) begin
      unique case (head.target)
        TGT_DEST_Y: work_y_ff <= head.data;
        TGT_DEST_X: work_x_ff <= head.data;
        TGT_ERR: work_err_ff <= head.data;
        TGT_MAJOR: work_major_ff <= head.data;
        TGT_CMD: cmd_ff <= head.data; // nop kept for later strokes
        TGT_STROKE: ;
      endcase
    end
  end

  // stroke vector order follows the byte order bit
  assign first_vec = cmd_ff[CMD_ORDER_BIT] ? head.data[7:0] : head.data[15:8]; // see RULE_22
  assign other_vec = cmd_ff[CMD_ORDER_BIT] ? head.data[15:8] : head.data[7:0]; // see RULE_22

  // build a command order from a command word and the working set
  function automatic dcr_draw_t build_cmd(input logic [15:0] w, input logic [15:0] y,
                                          input logic [15:0] x, input logic [15:0] e,
                                          input logic [15:0] m);
    dcr_draw_t d;
    d.op = w[CMD_OP_LSB +: 3]; // see RULE_19 RULE_21
    d.is_stroke = 1'b0;
    d.across_plane_select = w[CMD_ACROSS_BIT]; // see RULE_11
    d.final_pixel_suppress = w[CMD_SUPPRESS_BIT]; // see RULE_12
    d.direction_coding_select = w[CMD_CODING_BIT]; // see RULE_13
    d.draw_or_move_select = w[CMD_DRAW_BIT]; // see RULE_13
    d.draw_direction_field = w[CMD_DIR_LSB +: 3]; // see RULE_14
    d.host_data_wait = w[CMD_WAIT_BIT]; // see RULE_15
    d.xfer_width = w[CMD_WIDTH_LSB +: 2]; // see RULE_16
    // packed 32-bit code is only honoured for across-the-plane transfers
    d.width_code_ok = (w[CMD_WIDTH_LSB +: 2] != WIDTH_32_PACKED) || w[CMD_ACROSS_BIT]; // see RULE_17
    d.byte_order_select = w[CMD_ORDER_BIT]; // see RULE_18
    d.error_stepping = (w[CMD_OP_LSB +: 3] == OP_LINE) && !w[CMD_CODING_BIT]; // see RULE_20
    d.pixel_count = m[COORD_W-1:0]; // see RULE_06
    d.rect_top = y[COORD_W-1:0]; // see RULE_01
    d.rect_left = x[COORD_W-1:0]; // see RULE_03
    d.axial_step = y[STEP_W-1:0]; // see RULE_01
    d.diagonal_step = x[STEP_W-1:0]; // see RULE_03
    d.error_initial = e[STEP_W-1:0];
    return d;
  endfunction : build_cmd

  // a stroke vector is a radial line drawn with the last command's flags
  function automatic dcr_draw_t build_vec(input dcr_draw_t base, input logic [7:0] v);
    dcr_draw_t d;
    d = base;
    d.op = OP_LINE;
    d.is_stroke = 1'b1;
    d.direction_coding_select = 1'b1;
    d.error_stepping = 1'b0;
    d.draw_or_move_select = v[VEC_DRAW_BIT]; // see RULE_22
    d.draw_direction_field = v[VEC_DIR_LSB +: 3]; // see RULE_22
    d.pixel_count = {{(COORD_W-VEC_LEN_W){1'b0}}, v[VEC_LEN_W-1:0]}; // see RULE_22
    return d;
  endfunction : build_vec

  ////////////////////////////////////////////////////////////////////////
  // dispatch state machine
  always_comb begin
    nxt_state = state_ff;
    nxt_draw = draw_ff;
    unique case (state_ff)
      ST_IDLE: begin
        if (pop && head.target == TGT_CMD && head.data[CMD_OP_LSB +: 3] != OP_NOP) begin
          nxt_draw = build_cmd(head.data, work_y_ff, work_x_ff, work_err_ff, work_major_ff);
          nxt_state = ST_ISSUE;
        end else if (pop && head.target == TGT_STROKE) begin
          nxt_draw = build_vec(build_cmd(cmd_ff, work_y_ff, work_x_ff, work_err_ff, work_major_ff),
                               first_vec);
          nxt_state = ST_ISSUE;
        end
      end
      ST_ISSUE: begin
        if (draw_ack) begin
          nxt_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (draw_done && second_pending_ff) begin
          nxt_draw = build_vec(draw_ff, second_vec_ff); // see RULE_22
          nxt_state = ST_ISSUE;
        end else if (draw_done) begin
          nxt_state = ST_IDLE;
        end
      end
    endcase
  end

  // state, order and request registers
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_ff <= ST_IDLE;
      draw_ff <= '0;
      draw_req_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      draw_ff <= nxt_draw;
      draw_req_ff <= (nxt_state == ST_ISSUE);
    end
  end

  // second vector of a stroke word waits for the first to finish
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      second_vec_ff <= '0;
      second_pending_ff <= 1'b0;
    end else if (state_ff == ST_IDLE && pop && head.target == TGT_STROKE) begin
      second_vec_ff <= other_vec;
      second_pending_ff <= 1'b1;
    end else if (state_ff == ST_RUN && draw_done) begin
      second_pending_ff <= 1'b0;
    end
  end

  // busy from order issue until the last done
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      busy_ff <= 1'b0;
    end else begin
      busy_ff <= (nxt_state != ST_IDLE); // see RULE_08
    end
  end

  assign host_rdata = rdata_ff;
  assign host_rvalid = rvalid_ff;
  assign draw_req = draw_req_ff;
  assign draw_order = draw_ff;

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  busy_status_a: assert property (host_rd && addr_tgt == TGT_CMD && host_addr == ADDR_CMD // see RULE_08
    |=> host_rdata[STAT_BUSY_BIT] == $past(busy_ff)) else $error("busy bit wrong");
  empty_status_a: assert property (host_rd && host_addr == ADDR_CMD // see RULE_09
    |=> host_rdata[STAT_EMPTY_BIT] == ($past(q_count) == '0)) else $error("empty bit wrong");
  thermo_empty_a: assert property (host_rd && host_addr == ADDR_CMD && q_count == '0 // see RULE_07
    |=> host_rdata[7:0] == 8'h00 && host_rdata[15:11] == 5'h00) else $error("free queue not zero");
  thermo_one_a: assert property (host_rd && host_addr == ADDR_CMD && q_count == CW'(1) // see RULE_07
    |=> host_rdata[15:11] == 5'h01 && host_rdata[7:0] == 8'h00) else $error("thermometer bad");
  cmd_push_a: assert property (host_wr && host_addr == ADDR_CMD && !q_full && !pop // see RULE_23
    |=> q_count == $past(q_count) + 1'b1) else $error("command not queued");
  req_hold_a: assert property (draw_req && !draw_ack |=> draw_req && $stable(draw_order)) // see RULE_19
    else $error("request dropped");
  done_idle_a: assert property (state_ff == ST_RUN && draw_done && !second_pending_ff // see RULE_08
    |=> !busy_ff && state_ff == ST_IDLE) else $error("busy stuck");
  stroke_len_a: assert property (draw_req && draw_order.is_stroke // see RULE_22
    |-> draw_order.pixel_count[COORD_W-1:VEC_LEN_W] == '0 && draw_order.direction_coding_select)
    else $error("stroke too long");
  line_mode_a: assert property ($rose(draw_req) && draw_order.op == OP_LINE // see RULE_20
    |-> draw_order.error_stepping == !draw_order.direction_coding_select) else $error("line mode wrong");
  top_row_a: assert property ($rose(draw_req) && !draw_order.is_stroke // see RULE_01
    |-> draw_order.rect_top == work_y_ff[COORD_W-1:0]) else $error("top row wrong");

  full_c: cover property (q_full ##1 host_wr);
  stroke_c: cover property (draw_req && draw_order.is_stroke && second_pending_ff);
  pattern_c: cover property (draw_req && draw_order.op == OP_PATTERN);
endmodule : dcr_front

// >>> verilog/dcr_pkg.sv
// dcr_pkg: register offsets, command fields, op codes and carrier types
// of the drawing engine command front end.
// assumes a 16-bit host register port and an engine datapath on sys_clk.
package dcr_pkg;

  ////////////////////////////////////////////////////////////////////////
  // host register offsets (status and command share one address)
  localparam logic [15:0] ADDR_DEST_Y = 16'h8ae8;
  localparam logic [15:0] ADDR_DEST_X = 16'h8ee8;
  localparam logic [15:0] ADDR_ERR = 16'h92e8;
  localparam logic [15:0] ADDR_MAJOR = 16'h96e8;
  localparam logic [15:0] ADDR_CMD = 16'h9ae8;
  localparam logic [15:0] ADDR_STROKE = 16'h9ee8;

  // field widths and the documented queue depth
  localparam int COORD_W = 12;
  localparam int STEP_W = 14;
  localparam int QUEUE_DEPTH = 13;

  // command word field positions
  localparam int CMD_ACROSS_BIT = 1;
  localparam int CMD_SUPPRESS_BIT = 2;
  localparam int CMD_CODING_BIT = 3;
  localparam int CMD_DRAW_BIT = 4;
  localparam int CMD_DIR_LSB = 5;
  localparam int CMD_WAIT_BIT = 8;
  localparam int CMD_WIDTH_LSB = 9;
  localparam int CMD_ORDER_BIT = 12;
  localparam int CMD_OP_LSB = 13;

  // stroke vector byte fields
  localparam int VEC_LEN_W = 4;
  localparam int VEC_DRAW_BIT = 4;
  localparam int VEC_DIR_LSB = 5;

  // status word field positions
  localparam int STAT_BUSY_BIT = 9;
  localparam int STAT_EMPTY_BIT = 10;

  // reset values (power-on contents are undefined; parameters cleared here, command word set to 0001)
  localparam logic [15:0] PARAM_RESET = 16'h0000;
  localparam logic [15:0] CMD_RESET = 16'h0001;

  // operation codes
  localparam logic [2:0] OP_NOP = 3'h0;
  localparam logic [2:0] OP_LINE = 3'h1;
  localparam logic [2:0] OP_RECT = 3'h2;
  localparam logic [2:0] OP_BLOCK = 3'h6;
  localparam logic [2:0] OP_PATTERN = 3'h7;

  // transfer width codes
  localparam logic [1:0] WIDTH_32_PACKED = 2'h3;

  ////////////////////////////////////////////////////////////////////////
  // queue entry: which register was written and with what
  typedef enum logic [2:0] {TGT_DEST_Y, TGT_DEST_X, TGT_ERR, TGT_MAJOR, TGT_CMD, TGT_STROKE} dcr_target_t;

  typedef struct packed {
    dcr_target_t target;
    logic [15:0] data;
  } dcr_entry_t;

  // one drawing order handed to the pixel datapath
  typedef struct packed {
    logic [2:0] op;
    logic is_stroke;
    logic across_plane_select;
    logic final_pixel_suppress;
    logic direction_coding_select;
    logic draw_or_move_select;
    logic [2:0] draw_direction_field;
    logic host_data_wait;
    logic [1:0] xfer_width;
    logic width_code_ok;
    logic byte_order_select;
    logic error_stepping;
    logic [COORD_W-1:0] pixel_count;
    logic [COORD_W-1:0] rect_top;
    logic [COORD_W-1:0] rect_left;
    logic [STEP_W-1:0] axial_step;
    logic [STEP_W-1:0] diagonal_step;
    logic [STEP_W-1:0] error_initial;
  } dcr_draw_t;

endpackage : dcr_pkg

// >>> verilog/dcr_queue.sv
// dcr_queue: command queue, first word falls through, parameterised.
// assumes push and pop come from logic on sys_clk.
`timescale 1ns/1ns
module dcr_queue #(
  parameter int WIDTH = 19,
  parameter int DEPTH = 13
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // fill side
  input wire logic push,
  input wire logic [WIDTH-1:0] push_data,
  // drain side
  input wire logic pop,
  output logic [WIDTH-1:0] pop_data,
  // occupancy
  output logic [$clog2(DEPTH+1)-1:0] count,
  output logic empty,
  output logic full
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH+1);

  initial begin
    if (DEPTH < 2 || WIDTH < 1) $error("dcr_queue: unsupported size");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr_ff;
  logic [PW-1:0] rd_ptr_ff;
  logic [CW-1:0] count_ff;
  logic do_push;
  logic do_pop;

  ////////////////////////////////////////////////////////////////////////
  // a push into a full queue is dropped, a pop from empty ignored
  assign do_push = push && (count_ff != CW'(DEPTH));
  assign do_pop = pop && (count_ff != '0);
  assign pop_data = mem[rd_ptr_ff];
  assign count = count_ff;
  assign empty = (count_ff == '0);
  assign full = (count_ff == CW'(DEPTH));

  // storage array
  always_ff @(posedge sys_clk) begin
    if (do_push) begin
      mem[wr_ptr_ff] <= push_data;
    end
  end

  // pointers wrap at depth
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
    end else begin
      if (do_push) begin
        wr_ptr_ff <= (wr_ptr_ff == PW'(DEPTH-1)) ? '0 : wr_ptr_ff + 1'b1;
      end
      if (do_pop) begin
        rd_ptr_ff <= (rd_ptr_ff == PW'(DEPTH-1)) ? '0 : rd_ptr_ff + 1'b1;
      end
    end
  end

  // occupancy counter
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      count_ff <= '0;
    end else if (do_push && !do_pop) begin
      count_ff <= count_ff + 1'b1;
    end else if (do_pop && !do_push) begin
      count_ff <= count_ff - 1'b1;
    end
  end
endmodule : dcr_queue

// >>> dv/dcr_engine_model.sv
// dcr_engine_model: pixel datapath stand-in that accepts and finishes orders.
// assumes the front end drives draw_req and draw_order on sys_clk.
`timescale 1ns/1ns
module dcr_engine_model (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // order link
  input wire logic draw_req,
  input dcr_pkg::dcr_draw_t draw_order,
  output logic draw_ack,
  output logic draw_done,
  // test control and record of accepted orders
  input wire logic stall,
  output dcr_pkg::dcr_draw_t taken,
  output int n_taken
);
  import dcr_pkg::*;
  logic running_ff;
  int wait_ff;
  ////////////////////////////////////////////////////////////////////////
  // ack a pending order unless stalled, finish it five cycles later
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      draw_ack <= 1'b0;
      draw_done <= 1'b0;
      running_ff <= 1'b0;
      wait_ff <= 0;
      taken <= '0;
      n_taken <= 0;
    end else begin
      draw_ack <= 1'b0;
      draw_done <= 1'b0;
      if (draw_req && !running_ff && !draw_ack && !stall) begin
        draw_ack <= 1'b1;
        taken <= draw_order;
        n_taken <= n_taken + 1;
        running_ff <= 1'b1;
        wait_ff <= 3;
      end else if (running_ff && !draw_ack) begin
        if (wait_ff == 0) begin
          draw_done <= 1'b1;
          running_ff <= 1'b0;
        end else begin
          wait_ff <= wait_ff - 1;
        end
      end
    end
  end
endmodule : dcr_engine_model

// >>> dv/tb_top.sv
// tb_top: self-checking bench for the drawing command front end.
// assumes host strobes on sys_clk, driven at the falling edge.
`timescale 1ns/1ns
module tb_top;
  import dcr_pkg::*;
  logic sys_clk, reset_n, host_wr, host_rd, host_rvalid, draw_req, draw_ack, draw_done, stall;
  logic [15:0] host_addr, host_wdata, host_rdata, rd_val;
  dcr_draw_t draw_order, taken;
  int n_taken, bad_count, tests_run;
  // line from dx=5, dy=3, start x below end x: axial, diagonal, error, count
  logic [15:0] pa [4] = '{ADDR_DEST_Y, ADDR_DEST_X, ADDR_ERR, ADDR_MAJOR};
  logic [15:0] pv [4] = '{16'h0006, 16'h3ffc, 16'h0000, 16'h0005};
  // command words, bit 0 always set, covering every width code
  logic [15:0] cw [5] = '{16'h20b5, 16'h337b, 16'h45f1, 16'hd70f, 16'he6d1};
  dcr_front u_dut (.sys_clk(sys_clk), .reset_n(reset_n), .host_addr(host_addr), .host_wr(host_wr),
    .host_rd(host_rd), .host_wdata(host_wdata), .host_rdata(host_rdata), .host_rvalid(host_rvalid),
    .draw_req(draw_req), .draw_order(draw_order), .draw_ack(draw_ack), .draw_done(draw_done));
  dcr_engine_model u_engine (.sys_clk(sys_clk), .reset_n(reset_n), .draw_req(draw_req),
    .draw_order(draw_order), .draw_ack(draw_ack), .draw_done(draw_done), .stall(stall),
    .taken(taken), .n_taken(n_taken));
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  ////////////////////////////////////////////////////////////////////////
  // shared tasks
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic hwr(input logic [15:0] a, input logic [15:0] d);
    @(negedge sys_clk);
    host_wr = 1'b1;
    host_addr = a;
    host_wdata = d;
    @(negedge sys_clk);
    host_wr = 1'b0;
  endtask : hwr
  task automatic hrd(input logic [15:0] a);
    @(negedge sys_clk);
    host_rd = 1'b1;
    host_addr = a;
    @(negedge sys_clk);
    host_rd = 1'b0;
    chk("rvalid", {15'h0, host_rvalid}, 16'h0001);
    rd_val = host_rdata;
  endtask : hrd
  task automatic wait_orders(input int n);
    for (int i = 0; i < 200 && n_taken < n; i++) @(negedge sys_clk);
    chk("orders", n_taken[15:0], n[15:0]);
  endtask : wait_orders
  // occupancy thermometer: position p set when free slots are fewer than p
  function automatic logic [15:0] therm(input int used);
    logic [15:0] s;
    s = 16'h0000;
    for (int p = 1; p <= 13; p++) if (13 - used < p) s[p <= 8 ? 8 - p : 24 - p] = 1'b1;
    return s;
  endfunction : therm
  task automatic chk_vec(input logic [7:0] v);
    chk("stroke", {taken.is_stroke, taken.op, taken.direction_coding_select}, 5'h13);
    chk("vec_draw", taken.draw_or_move_select, v[4]);
    chk("vec_dir", taken.draw_direction_field, v[7:5]);
    chk("vec_len", taken.pixel_count, {8'h00, v[3:0]});
  endtask : chk_vec
  ////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_reset;
    hrd(ADDR_CMD);
    chk("status", rd_val, 16'h0400);
    for (int i = 0; i < 4; i++) begin
      hrd(pa[i]);
      chk("param_reset", rd_val, PARAM_RESET);
    end
    hrd(16'h1234);
    chk("unmapped", rd_val, 16'h0000);
    $display("test reset done");
  endtask : t_reset
  task automatic t_params;
    for (int i = 0; i < 4; i++) hwr(pa[i], pv[i]);
    for (int i = 0; i < 4; i++) begin
      hrd(pa[i]);
      chk("param_read", rd_val, pv[i]);
    end
    $display("test params done");
  endtask : t_params
  task automatic t_cmds;
    logic [15:0] w;
    for (int i = 0; i < 5; i++) begin
      w = cw[i];
      hwr(ADDR_CMD, w);
      wait_orders(i + 1);
      chk("op", taken.op, w[15:13]);
      chk("across", taken.across_plane_select, w[1]);
      chk("suppress", taken.final_pixel_suppress, w[2]);
      chk("coding_draw", {taken.draw_or_move_select, taken.direction_coding_select}, w[4:3]);
      chk("dir", taken.draw_direction_field, w[7:5]);
      chk("wait", taken.host_data_wait, w[8]);
      chk("width", taken.xfer_width, w[10:9]);
      chk("width_ok", taken.width_code_ok, !(w[10:9] == 2'h3 && !w[1]));
      chk("order", taken.byte_order_select, w[12]);
      chk("stepping", taken.error_stepping, w[15:13] == OP_LINE && !w[3]);
      chk("top", taken.rect_top, pv[0][11:0]);
      chk("left", taken.rect_left, pv[1][11:0]);
      chk("axial", taken.axial_step, pv[0][13:0]);
      chk("diag", taken.diagonal_step, pv[1][13:0]);
      chk("err", taken.error_initial, pv[2][13:0]);
      chk("count", taken.pixel_count, pv[3][11:0]);
    end
    chk("pattern", taken.op, OP_PATTERN);
    $display("test commands done");
  endtask : t_cmds
  task automatic t_fill;
    int n;
    n = n_taken;
    stall = 1'b1;
    hwr(ADDR_CMD, cw[0]);
    for (int i = 0; i < 50 && draw_req !== 1'b1; i++) @(negedge sys_clk);
    // one more write than the queue holds; the last is dropped
    for (int k = 1; k <= 14; k++) begin
      hwr(ADDR_CMD, cw[0]);
      hrd(ADDR_CMD);
      chk("fill_status", rd_val, therm(k > 13 ? 13 : k) | 16'h0200);
    end
    chk("req_held", {15'h0, draw_req}, 16'h0001);
    stall = 1'b0;
    wait_orders(n + 14);
    for (int i = 0; i < 50 && rd_val !== 16'h0400; i++) hrd(ADDR_CMD);
    chk("idle_status", rd_val, 16'h0400);
    chk("dropped", n_taken[15:0], n[15:0] + 16'd14);
    $display("test fill done");
  endtask : t_fill
  task automatic t_stroke;
    int n;
    for (int s = 0; s < 2; s++) begin
      n = n_taken;
      hwr(ADDR_CMD, {3'h0, s[0], 12'h001});
      repeat (4) @(negedge sys_clk);
      chk("nop_silent", n_taken[15:0], n[15:0]);
      hwr(ADDR_STROKE, 16'hb53c);
      wait_orders(n + 1);
      chk_vec(s ? 8'h3c : 8'hb5);
      wait_orders(n + 2);
      chk_vec(s ? 8'hb5 : 8'h3c);
    end
    $display("test stroke done");
  endtask : t_stroke
  ////////////////////////////////////////////////////////////////////////
  // closing, main sequence and watchdog
  task automatic end_sim;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_sim
  initial begin
    reset_n = 1'b0;
    host_wr = 1'b0;
    host_rd = 1'b0;
    host_addr = 16'h0000;
    host_wdata = 16'h0000;
    stall = 1'b0;
    bad_count = 0;
    tests_run = 0;
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
    reset_n = 1'b1;
    t_reset;
    t_params;
    t_cmds;
    t_fill;
    t_stroke;
    end_sim;
  end
  initial begin
    #200000;
    bad_count++;
    end_sim;
  end
endmodule : tb_top
